// File: rtl/flash_self_program_control.sv
// flash self-programming controller: table access, holding buffer,
// unlock key and self-timed program / erase sequencer
// assumes a classic wishbone master on clk_in and a core that honours
// cpu_stall_out; the flash array is modelled by an internal memory
//
// Notes on behaviour
// RL1 - table address is table page low byte joined with effective address
// RL2 - low-word table access covers program word bits 15 to 0
// RL3 - high-byte table access covers program word bits 23 to 16
// RL4 - array rows hold 64 instructions, 192 bytes of program space
// RL5 - erase one eight-row page, program one row or one word
// RL6 - pages align on 1536 bytes, rows on 192 bytes
// RL7 - 64-word holding buffer, loaded sequentially within one aligned row
// RL8 - table writes touch only the holding buffer, never the array
// RL9 - every row needs its own programming cycle after loading
// RL10 - core is stalled while program or erase runs
// RL11 - duration is counted in fast rc cycles; row write 11064
// RL12 - start bit is set-only, hardware clears it on completion
// RL13 - software writes 0x55 then 0xAA to the key before start
// RL14 - key is write-only, low byte used, upper bits read zero
// RL15 - permit bit enables program and erase, clear inhibits them
// RL16 - sequence fault set on bad start or abort, cleared on success
// RL17 - erase bit picks erase, else program, for next start
// RL18 - erase codes: F bulk, D general, C secure, 2 page, 0 config
// RL19 - program codes: 3 word, 1 row, 0 config byte
// RL20 - codes E and B reserved, unlisted codes do nothing
// RL21 - control bits reset only on power-on reset
// RL22 - control bits 12..7 and 5..4 ignore writes, read zero
// RL23 - software places two no-ops after setting start
// RL24 - other write between keys cancels; bad start faults, array untouched
//
// Decided for this implementation: the Wishbone interface to the registers and the register offsets.
`include "flash_self_program_cfg.svh"
`timescale 1ns/100ps

module flash_self_program_control
#(
	parameter int ROW_FRC  = `ROW_WRITE_FRC,
	parameter int PAGE_FRC = `PAGE_ERASE_FRC,
	parameter int BULK_FRC = `BULK_ERASE_FRC
)
(
	// clock and resets
	input  wire logic                            clk_in,
	input  wire logic                            nrst_in,
	input  wire logic                            nrst_sys_in,
	// register bus
	input  wire flash_self_program_pkg::wb_req_t wb_req_in,
	output logic [31:0]                          wb_dat_out,
	output logic                                 wb_ack_out,
	// core
	output logic                                 cpu_stall_out
);
	import flash_self_program_pkg::*;

	//--------------------------------------------------------------
	// state
	//--------------------------------------------------------------
	ctrl_t               ctrl;
	ctrl_t               next_ctrl;
	key_state_t          key;
	key_state_t          next_key;
	seq_state_t          seq;
	seq_state_t          next_seq;
	flash_op_t           run_op;
	logic [`ARR_AW-1:0]  run_base;
	logic [11:0]         walk;
	logic [11:0]         next_walk;
	logic [15:0]         frc_cnt;
	logic [15:0]         next_frc;
	logic [15:0]         frc_acc;
	logic [7:0]          page;
	logic [15:0]         ea;
	logic [23:0]         last_addr;
	logic [23:0]         hold [`ROW_WORDS];
	logic [23:0]         array_mem [`ARRAY_WORDS];
	logic [7:0]          cfg_mem [`CFG_BYTES];

	//--------------------------------------------------------------
	// helpers
	//--------------------------------------------------------------
	function automatic logic [`ARR_AW-1:0] arr_idx(input logic [23:0] a);
		return a[`ARR_AW:1];
	endfunction

	function automatic flash_op_t decode_op(input logic erase,
		input logic [3:0] code);
		flash_op_t r;
		r = OP_NONE;
		if (erase)
			case (code) // RL17 RL18
				`OPC_BULK: r = OP_BULK;
				`OPC_GSEG: r = OP_GEN_SEG;
				`OPC_SSEG: r = OP_SEC_SEG;
				`OPC_PAGE: r = OP_PAGE;
				`OPC_CFG:  r = OP_CFG_ERASE;
				default:   r = OP_NONE; // RL20
			endcase
		else
			case (code) // RL17 RL19
				`OPC_WORD: r = OP_WORD;
				`OPC_ROW:  r = OP_ROW;
				`OPC_CFG:  r = OP_CFG_PROG;
				default:   r = OP_NONE; // RL20
			endcase
		return r;
	endfunction

	// array words, or config bytes for config operations, touched by each operation
	function automatic logic [11:0] op_span(input flash_op_t op);
		case (op)
			OP_ROW:     return `ROW_WORDS; // RL4 RL5
			OP_PAGE:    return `PAGE_WORDS; // RL5
			OP_BULK,
			OP_GEN_SEG: return `ARRAY_WORDS;
			OP_SEC_SEG: return 12'h000; // no secure segment in this array
			default:    return 12'h001;
		endcase
	endfunction

	// duration in fast rc cycles
	function automatic logic [15:0] op_dur(input flash_op_t op);
		case (op)
			OP_ROW:       return 16'(ROW_FRC); // RL11
			OP_PAGE:      return 16'(PAGE_FRC);
			OP_BULK,
			OP_GEN_SEG,
			OP_SEC_SEG:   return 16'(BULK_FRC);
			OP_WORD:      return `WORD_WRITE_FRC;
			default:      return `CFG_WRITE_FRC;
		endcase
	endfunction

	//--------------------------------------------------------------
	// bus decode
	//--------------------------------------------------------------
	wire         access   = wb_req_in.cyc & wb_req_in.stb & ~wb_ack_out;
	wire         wr       = access & wb_req_in.we;
	wire         rd       = access & ~wb_req_in.we;
	wire [31:0]  dat      = wb_req_in.dat;
	wire [3:0]   sel      = wb_req_in.sel;
	wire         hit_ctrl = wb_req_in.adr == `CTRL_OFS;
	wire         hit_key  = wb_req_in.adr == `KEY_OFS;
	wire         hit_page = wb_req_in.adr == `PAGE_OFS;
	wire         hit_ea   = wb_req_in.adr == `EA_OFS;
	wire         hit_low  = wb_req_in.adr == `LOW_OFS;
	wire         hit_high = wb_req_in.adr == `HIGH_OFS;
	wire         hit_stat = wb_req_in.adr == `STAT_OFS;
	wire         idle     = seq == SEQ_IDLE;
	wire         bus_rst  = ~nrst_in | ~nrst_sys_in;

	//--------------------------------------------------------------
	// table access
	//--------------------------------------------------------------
	wire [23:0] tbl_addr = {page, ea}; // RL1
	wire [5:0]  hidx     = tbl_addr[6:1]; // RL7
	wire [23:0] rd_word  = page[7]
		? {16'h0000, cfg_mem[tbl_addr[`CFG_AW:1]]}
		: array_mem[arr_idx(tbl_addr)];

	always_ff @(posedge clk_in)
	begin
		if (bus_rst)
		begin
			page <= 8'h00;
			ea   <= 16'h0000;
		end
		else
		begin
			if (wr && hit_page && sel[0])
				page <= dat[7:0];
			if (wr && hit_ea && sel[0])
				ea[7:0] <= dat[7:0];
			if (wr && hit_ea && sel[1])
				ea[15:8] <= dat[15:8];
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (bus_rst)
			last_addr <= 24'h000000;
		else if (wr && (hit_low || hit_high))
			last_addr <= tbl_addr;
	end

	// byte lanes give byte mode; the buffer is the only target
	always_ff @(posedge clk_in)
	begin
		if (wr && hit_low && sel[0])
			hold[hidx][7:0] <= dat[7:0]; // RL2 RL8
		if (wr && hit_low && sel[1])
			hold[hidx][15:8] <= dat[15:8]; // RL2 RL8
		if (wr && hit_high && sel[0])
			hold[hidx][23:16] <= dat[7:0]; // RL3 RL8
	end

	//--------------------------------------------------------------
	// unlock key
	//--------------------------------------------------------------
	wire key_lo = dat[7:0] == `KEY_FIRST;
	wire key_hi = dat[7:0] == `KEY_SECOND;

	// any write other than the second key closes the lock again
	always_comb
	begin
		next_key = key;
		if (wr && hit_key && key == KEY_HALF && key_hi)
			next_key = KEY_OPEN; // RL13
		else if (wr && hit_key && key_lo)
			next_key = KEY_HALF;
		else if (wr)
			next_key = KEY_IDLE; // RL24
	end

	always_ff @(posedge clk_in)
	begin
		if (bus_rst)
			key <= KEY_IDLE;
		else
			key <= next_key;
	end

	//--------------------------------------------------------------
	// control register
	//--------------------------------------------------------------
	// writes are ignored while an operation runs (core is stalled)
	wire       ctrl_wr    = wr & hit_ctrl & idle;
	wire       new_erase  = (ctrl_wr & sel[0]) ? dat[`ERASE_BIT] : ctrl.erase;
	wire [3:0] new_op     = (ctrl_wr & sel[0]) ? dat[3:0] : ctrl.op;
	wire       new_permit = (ctrl_wr & sel[1]) ? dat[`PERMIT_BIT]
		: ctrl.permit;
	wire       new_fault  = (ctrl_wr & sel[1]) ? dat[`FAULT_BIT] : ctrl.fault;
	wire       start_req  = ctrl_wr & sel[1] & dat[`START_BIT];
	wire       armed      = key == KEY_OPEN;
	flash_op_t req_op;
	assign     req_op     = decode_op(new_erase, new_op);
	wire       bad_start  = start_req & ~(armed & new_permit); // RL15 RL24
	wire       go         = start_req & armed & new_permit
		& (req_op != OP_NONE);
	wire       sys_abort  = ~nrst_sys_in & ~idle;

	always_comb
	begin
		next_ctrl        = ctrl;
		next_ctrl.erase  = new_erase;
		next_ctrl.op     = new_op;
		next_ctrl.permit = new_permit;
		next_ctrl.fault  = new_fault;
		if (bad_start || sys_abort)
			next_ctrl.fault = 1'b1; // RL16
		if (go)
			next_ctrl.start = 1'b1; // RL12
		if (seq == SEQ_DONE)
		begin
			next_ctrl.start = 1'b0; // RL12
			next_ctrl.fault = 1'b0; // RL16
		end
		if (sys_abort)
			next_ctrl.start = 1'b0;
	end

	// only the power-on reset clears it; the system reset does not
	always_ff @(posedge clk_in)
	begin
		if (!nrst_in)
			ctrl <= ctrl_t'(`CTRL_RESET); // RL21
		else
			ctrl <= next_ctrl;
	end

	//--------------------------------------------------------------
	// fast rc time base
	//--------------------------------------------------------------
	// fractional accumulator: 7370 ticks per 40000 bus clocks
	wire [15:0] acc_sum  = frc_acc + `FRC_KHZ;
	wire        frc_tick = acc_sum >= `CLK_KHZ; // RL11

	always_ff @(posedge clk_in)
	begin
		if (!nrst_in)
			frc_acc <= 16'h0000;
		else
			frc_acc <= frc_tick ? acc_sum - `CLK_KHZ : acc_sum;
	end

	//--------------------------------------------------------------
	// sequencer
	//--------------------------------------------------------------
	wire [11:0] span     = op_span(run_op);
	wire [15:0] dur_m1   = op_dur(run_op) - 16'h0001;
	wire        walking  = (seq == SEQ_RUN) && (walk != span);
	wire        run_cfg  = (run_op == OP_CFG_PROG) || (run_op == OP_CFG_ERASE);
	wire        run_prog = (run_op == OP_ROW) || (run_op == OP_WORD)
		|| (run_op == OP_CFG_PROG);
	wire        time_up  = frc_tick && (frc_cnt >= dur_m1);

	// aligned bases: rows on 128 addresses, pages on 1024
	wire [`ARR_AW-1:0] row_base  = arr_idx({last_addr[23:`ROW_LSB],
		7'h00}); // RL6
	wire [`ARR_AW-1:0] page_base = arr_idx({last_addr[23:`PAGE_LSB],
		10'h000}); // RL6
	wire [`ARR_AW-1:0] start_base = (req_op == OP_ROW) ? row_base
		: (req_op == OP_PAGE) ? page_base
		: (req_op == OP_WORD) ? arr_idx(last_addr)
		: {`ARR_AW{1'b0}};

	always_comb
	begin
		next_seq  = seq;
		next_walk = walk;
		next_frc  = frc_cnt;
		case (seq)
			SEQ_IDLE:
				if (go)
				begin
					next_seq  = SEQ_RUN;
					next_walk = 12'h000;
					next_frc  = 16'h0000;
				end
			SEQ_RUN:
			begin
				if (walk != span)
					next_walk = walk + 12'h001;
				if (time_up && walk == span)
					next_seq = SEQ_DONE; // RL11
				else if (frc_tick)
					next_frc = frc_cnt + 16'h0001;
			end
			SEQ_DONE:
				next_seq = SEQ_IDLE;
			default:
				next_seq = SEQ_IDLE;
		endcase
	end

	always_ff @(posedge clk_in)
	begin
		if (bus_rst)
			seq <= SEQ_IDLE;
		else
			seq <= next_seq;
		walk    <= next_walk;
		frc_cnt <= next_frc;
	end

	always_ff @(posedge clk_in)
	begin
		if (bus_rst)
		begin
			run_op   <= OP_NONE;
			run_base <= {`ARR_AW{1'b0}};
		end
		else if (go)
		begin
			run_op   <= req_op;
			run_base <= start_base;
		end
	end

	assign cpu_stall_out = seq == SEQ_RUN; // RL10

	//--------------------------------------------------------------
	// array update
	//--------------------------------------------------------------
	// programming can only clear bits, as in a real flash cell
	wire [`ARR_AW-1:0] arr_wi   = run_base + walk[`ARR_AW-1:0];
	wire [23:0]        prog_wd  = (run_op == OP_ROW) ? hold[walk[5:0]]
		: hold[last_addr[6:1]]; // RL9
	wire [23:0]        arr_wd   = run_prog ? (array_mem[arr_wi] & prog_wd)
		: `ERASED_WORD;
	wire               arr_we   = walking & ~run_cfg;
	wire [`CFG_AW-1:0] cfg_wi   = last_addr[`CFG_AW:1];
	wire [7:0]         cfg_wd   = run_prog
		? (cfg_mem[cfg_wi] & hold[last_addr[6:1]][7:0]) : `ERASED_BYTE;

	always_ff @(posedge clk_in)
	begin
		if (arr_we)
			array_mem[arr_wi] <= arr_wd; // RL5 RL8
		if (walking && run_cfg)
			cfg_mem[cfg_wi] <= cfg_wd;
	end

	//--------------------------------------------------------------
	// bus answer
	//--------------------------------------------------------------
	wire [31:0] ctrl_rd = {16'h0000, ctrl.start, ctrl.permit, ctrl.fault,
		6'h00, ctrl.erase, 2'b00, ctrl.op}; // RL22
	wire [31:0] rd_mux  = hit_ctrl ? ctrl_rd
		: hit_page ? {24'h000000, page}
		: hit_ea   ? {16'h0000, ea}
		: hit_low  ? {16'h0000, rd_word[15:0]} // RL2
		: hit_high ? {24'h000000, rd_word[23:16]} // RL3
		: hit_stat ? {30'h00000000, armed, cpu_stall_out}
		: 32'h00000000; // RL14

	always_ff @(posedge clk_in)
	begin
		if (bus_rst)
		begin
			wb_ack_out <= 1'b0;
			wb_dat_out <= 32'h00000000;
		end
		else
		begin
			wb_ack_out <= access;
			wb_dat_out <= rd ? rd_mux : 32'h00000000;
		end
	end

	//--------------------------------------------------------------
	// checks
	//--------------------------------------------------------------
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (bus_rst);

	sequence s_key_first;
		wr && hit_key && key_lo;
	endsequence

	sequence s_key_second;
		wr && hit_key && key_hi && key == KEY_HALF;
	endsequence

	a_key_first_arms: assert property (s_key_first |=> key == KEY_HALF)
		else $error("first key did not arm"); // RL13
	a_key_second_opens: assert property (s_key_second |=> armed)
		else $error("second key did not open"); // RL13
	a_other_write_closes: assert property (
		wr && !hit_key |=> key == KEY_IDLE)
		else $error("unlock survived another write"); // RL24
	a_bad_start_faults: assert property (
		bad_start |=> ctrl.fault && !ctrl.start ##1 idle)
		else $error("bad start not flagged"); // RL24
	a_no_permit_no_run: assert property (
		start_req && !new_permit |=> idle[*2])
		else $error("operation ran while inhibited"); // RL15
	a_start_needs_key: assert property (
		$rose(ctrl.start) |-> $past(key) == KEY_OPEN)
		else $error("start without unlock"); // RL24
	a_stall_during_run: assert property (
		seq == SEQ_RUN |-> cpu_stall_out && ctrl.start)
		else $error("core not stalled while busy"); // RL10
	a_done_clears: assert property (
		seq == SEQ_RUN ##1 seq == SEQ_DONE
		|=> !ctrl.start && !ctrl.fault && !cpu_stall_out)
		else $error("completion did not clear start"); // RL12
	a_run_duration: assert property (
		seq == SEQ_RUN && next_seq == SEQ_DONE
		|-> frc_tick && frc_cnt >= dur_m1)
		else $error("operation ended early"); // RL11
	a_array_only_running: assert property (arr_we |-> seq == SEQ_RUN)
		else $error("array written outside an operation"); // RL8
	a_key_reads_zero: assert property (
		rd && hit_key |=> wb_ack_out && wb_dat_out == 32'h00000000)
		else $error("key register readable"); // RL14
	a_ctrl_gaps_zero: assert property (
		rd && hit_ctrl |=> wb_dat_out[12:7] == 6'h00
		&& wb_dat_out[5:4] == 2'b00)
		else $error("unimplemented control bits set"); // RL22
	a_bus_single_ack: assert property (access |=> wb_ack_out ##1 !wb_ack_out)
		else $error("ack not a single cycle");

endmodule // flash_self_program_control

// File: rtl/flash_self_program_cfg.svh
// offsets, field positions, opcodes and timing counts of the flash
// self-programming controller; included by the controller and by both testbench files
`ifndef FLASH_SELF_PROGRAM_CFG_SVH
`define FLASH_SELF_PROGRAM_CFG_SVH

// register byte offsets on the bus
`define CTRL_OFS 8'h00
`define KEY_OFS 8'h04
`define PAGE_OFS 8'h08
`define EA_OFS 8'h0C
`define LOW_OFS 8'h10
`define HIGH_OFS 8'h14
`define STAT_OFS 8'h18

// control register fields
`define START_BIT 15
`define PERMIT_BIT 14
`define FAULT_BIT 13
`define ERASE_BIT 6
`define CTRL_RESET 8'h00

// unlock key values
`define KEY_FIRST 8'h55
`define KEY_SECOND 8'hAA

// operation select codes
`define OPC_BULK 4'hF
`define OPC_GSEG 4'hD
`define OPC_SSEG 4'hC
`define OPC_PAGE 4'h2
`define OPC_WORD 4'h3
`define OPC_ROW 4'h1
`define OPC_CFG 4'h0

// geometry; addresses count two per instruction word
`define ROW_WORDS 12'h040
`define PAGE_WORDS 12'h200
`define ARRAY_WORDS 12'h800
`define ROW_LSB 7
`define PAGE_LSB 10
`define ARR_AW 11
`define CFG_AW 4
`define CFG_BYTES 16
`define ERASED_WORD 24'hFFFFFF
`define ERASED_BYTE 8'hFF

// timing: fast rc rate 7.37 MHz against the 40 MHz bus clock, in kHz
`define FRC_KHZ 16'h1CCA
`define CLK_KHZ 16'h9C40
`define ROW_WRITE_FRC 11064
`define PAGE_ERASE_FRC 8192
`define BULK_ERASE_FRC 16384
`define WORD_WRITE_FRC 16'h0200
`define CFG_WRITE_FRC 16'h0200

`endif

// File: rtl/flash_self_program_pkg.sv
// types shared by the flash self-programming controller
// assumes the _cfg header supplies all numeric constants
package flash_self_program_pkg;

	typedef enum logic [3:0] {
		OP_NONE, OP_ROW, OP_WORD, OP_CFG_PROG, OP_PAGE,
		OP_BULK, OP_GEN_SEG, OP_SEC_SEG, OP_CFG_ERASE
	} flash_op_t;

	typedef enum logic [1:0] {KEY_IDLE, KEY_HALF, KEY_OPEN} key_state_t;

	typedef enum logic [1:0] {SEQ_IDLE, SEQ_RUN, SEQ_DONE} seq_state_t;

	// classic wishbone request from the master
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic [7:0]  adr;
		logic        we;
		logic [3:0]  sel;
		logic [31:0] dat;
	} wb_req_t;

	typedef struct packed {
		logic       start;
		logic       permit;
		logic       fault;
		logic       erase;
		logic [3:0] op;
	} ctrl_t;

endpackage

// File: testbench/cpu_core_model.sv
// core model: a classic wishbone master issuing register and table accesses
// assumes the controller answers every request and stalls the core
`include "flash_self_program_cfg.svh"
`timescale 1ns/100ps
module cpu_core_model
(
	// clock
	input  wire logic                            clk_in,
	// controller answers
	input  wire logic [31:0]                     wb_dat_in,
	input  wire logic                            wb_ack_in,
	input  wire logic                            cpu_stall_in,
	// request
	output flash_self_program_pkg::wb_req_t      wb_req_out
);
	import flash_self_program_pkg::*;

	initial wb_req_out = '0;

	// a stalled core issues nothing, so every access waits for the run
	task automatic bus(input logic [7:0] adr, input logic we,
		input logic [3:0] sel, input logic [31:0] dat,
		output logic [31:0] rd);
		while (cpu_stall_in === 1'b1) @(posedge clk_in);
		@(posedge clk_in);
		wb_req_out <= '{1'b1, 1'b1, adr, we, sel, dat};
		do @(posedge clk_in); while (wb_ack_in !== 1'b1);
		rd = wb_dat_in;
		wb_req_out <= '0;
	endtask

	task automatic wr(input logic [7:0] adr, input logic [3:0] sel,
		input logic [31:0] dat);
		logic [31:0] x;
		bus(adr, 1'b1, sel, dat, x);
	endtask

	task automatic rd(input logic [7:0] adr, output logic [31:0] d);
		bus(adr, 1'b0, 4'hF, 32'h0, d);
	endtask

	function automatic logic [23:0] pat(input int i);
		return {8'(i) ^ 8'h3C, 8'(i), 8'hC0 + 8'(i)};
	endfunction

	// the two keys go back to back, nothing else in between
	task automatic unlock();
		wr(`KEY_OFS, 4'h1, 32'h55);
		wr(`KEY_OFS, 4'h1, 32'hAA);
	endtask

	task automatic start(input logic [15:0] ctrl);
		unlock();
		wr(`CTRL_OFS, 4'h3, {16'h0, ctrl});
		repeat (2) @(posedge clk_in);
	endtask

	// one aligned row, loaded in ascending order
	task automatic load_row(input logic [15:0] base);
		for (int i = 0; i < 64; i++)
		begin
			wr(`EA_OFS, 4'h3, {16'h0, base + 16'(2 * i)});
			wr(`LOW_OFS, 4'h3, {16'h0, pat(i)[15:0]});
			wr(`HIGH_OFS, 4'h1, {24'h0, pat(i)[23:16]});
		end
	endtask
endmodule // cpu_core_model

// File: testbench/flash_self_program_control_test.sv
// self-checking bench of the flash self-programming controller
// assumes cpu_core_model drives the register bus as the core
`include "flash_self_program_cfg.svh"
`timescale 1ns/100ps
module flash_self_program_control_test;
	import flash_self_program_pkg::*;

	// short counts keep the run small
	localparam int ROW_N  = 40;
	localparam int PAGE_N = 100;
	localparam int BULK_N = 400;

	typedef struct packed {logic [15:0] ctrl; logic run;} code_row_t;

	logic        clk_in      = 1'b0;
	logic        nrst_in     = 1'b0;
	logic        nrst_sys_in = 1'b0;
	wb_req_t     wb_req;
	logic [31:0] wb_dat;
	logic        wb_ack;
	logic        stall;
	logic [31:0] d;
	int          n;
	int          error_cnt = 0;
	int          checked   = 0;
	int          cyc_cnt   = 0;
	code_row_t   rows[12]  = '{'{16'hC000, 1'b1}, '{16'hC040, 1'b1},
		'{16'hC04C, 1'b1}, '{16'hC04D, 1'b1}, '{16'hC00F, 1'b0},
		'{16'hC00D, 1'b0}, '{16'hC00C, 1'b0}, '{16'hC002, 1'b0},
		'{16'hC00E, 1'b0}, '{16'hC04B, 1'b0}, '{16'hC043, 1'b0},
		'{16'hC041, 1'b0}};

	always #12.5 clk_in = ~clk_in;

	flash_self_program_control #(.ROW_FRC(ROW_N), .PAGE_FRC(PAGE_N),
		.BULK_FRC(BULK_N)) uut (.clk_in(clk_in), .nrst_in(nrst_in),
		.nrst_sys_in(nrst_sys_in), .wb_req_in(wb_req), .wb_dat_out(wb_dat),
		.wb_ack_out(wb_ack), .cpu_stall_out(stall));

	cpu_core_model core (.clk_in(clk_in), .wb_dat_in(wb_dat),
		.wb_ack_in(wb_ack), .cpu_stall_in(stall), .wb_req_out(wb_req));

	//----------------------------------------------------------------
	// checking and closing
	//----------------------------------------------------------------
	task automatic test_done();
		$display("checks %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk_dat(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("BAD %0t data %h want %h", $time, got, exp);
		end
	endtask

	task automatic chk_flag(input logic got, input logic exp);
		checked++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("BAD %0t stall %b want %b", $time, got, exp);
		end
	endtask

	// run length allows for rounding of the fast rc tick
	task automatic chk_len(input int got, input int ticks);
		int e;
		e = ticks * 40000 / 7370;
		checked++;
		if (got < e - 6 || got > e + 4)
		begin
			error_cnt++;
			$display("BAD %0t run %0d cycles want %0d", $time, got, e);
		end
	endtask

	task automatic run_len(output int k);
		k = 0;
		while (stall === 1'b1)
		begin
			@(posedge clk_in);
			k++;
		end
	endtask

	task automatic rd_word(input logic [15:0] ea, input logic [23:0] exp);
		core.wr(`EA_OFS, 4'h3, {16'h0, ea});
		core.rd(`LOW_OFS, d);
		chk_dat(d, {16'h0, exp[15:0]});
		core.rd(`HIGH_OFS, d);
		chk_dat(d, {24'h0, exp[23:16]});
	endtask

	task automatic sys_pulse(input logic por);
		@(posedge clk_in);
		if (por)
			nrst_in <= 1'b0;
		else
			nrst_sys_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		nrst_in <= 1'b1;
		nrst_sys_in <= 1'b1;
		@(posedge clk_in);
	endtask

	always @(posedge clk_in)
	begin
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt == 40000)
		begin
			error_cnt++;
			test_done();
		end
	end

	//----------------------------------------------------------------
	// main sequence
	//----------------------------------------------------------------
	initial
	begin
		repeat (10) @(posedge clk_in);
		nrst_in <= 1'b1;
		nrst_sys_in <= 1'b1;
		@(posedge clk_in);
		core.wr(`CTRL_OFS, 4'h3, 32'h5FFF);
		core.rd(`CTRL_OFS, d);
		chk_dat(d, 32'h404F);
		core.wr(`CTRL_OFS, 4'h3, 32'h1FB0);
		core.rd(`CTRL_OFS, d);
		chk_dat(d, 32'h0);
		core.wr(`KEY_OFS, 4'h1, 32'h55);
		core.rd(`KEY_OFS, d);
		chk_dat(d, 32'h0);
		core.rd(8'h1C, d);
		chk_dat(d, 32'h0);
		// a read does not close the lock; the status word shows it open
		core.unlock();
		core.rd(`STAT_OFS, d);
		chk_dat(d, 32'h2);
		// page erase aimed mid-page must clear the whole aligned page
		core.wr(`PAGE_OFS, 4'h1, 32'h0);
		core.wr(`EA_OFS, 4'h3, 32'h0500);
		core.wr(`LOW_OFS, 4'h3, 32'h0);
		core.start(16'hC042);
		run_len(n);
		chk_len(n, PAGE_N);
		core.rd(`CTRL_OFS, d);
		chk_dat(d, 32'h4042);
		rd_word(16'h0400, 24'hFFFFFF);
		rd_word(16'h07FE, 24'hFFFFFF);
		// row load touches only the buffer until started
		core.load_row(16'h0480);
		rd_word(16'h0480, 24'hFFFFFF);
		core.start(16'hC001);
		run_len(n);
		chk_len(n, ROW_N);
		for (int i = 0; i < 64; i++)
			rd_word(16'h0480 + 16'(2 * i), core.pat(i));
		rd_word(16'h0400, 24'hFFFFFF);
		rd_word(16'h0500, 24'hFFFFFF);
		// bad starts: no key, broken key, writes inhibited
		core.wr(`CTRL_OFS, 4'h3, 32'hC003);
		core.rd(`CTRL_OFS, d);
		chk_dat(d, 32'h6003);
		core.wr(`CTRL_OFS, 4'h3, 32'h4003);
		core.wr(`KEY_OFS, 4'h1, 32'h55);
		core.wr(`PAGE_OFS, 4'h1, 32'h0);
		core.wr(`KEY_OFS, 4'h1, 32'hAA);
		core.wr(`CTRL_OFS, 4'h3, 32'hC003);
		core.rd(`CTRL_OFS, d);
		chk_dat(d, 32'h6003);
		core.wr(`CTRL_OFS, 4'h3, 32'h0003);
		core.start(16'h8003);
		chk_flag(stall, 1'b0);
		core.rd(`CTRL_OFS, d);
		chk_dat(d, 32'h2003);
		// single word program clears the fault
		core.wr(`EA_OFS, 4'h3, 32'h0400);
		core.wr(`LOW_OFS, 4'h3, 32'h1234);
		core.wr(`HIGH_OFS, 4'h1, 32'h56);
		core.start(16'hC003);
		run_len(n);
		chk_len(n, 512);
		core.rd(`CTRL_OFS, d);
		chk_dat(d, 32'h4003);
		rd_word(16'h0400, 24'h561234);
		rd_word(16'h0402, 24'hFFFFFF);
		// only a power-on reset clears the control register
		core.wr(`CTRL_OFS, 4'h3, 32'h4042);
		sys_pulse(1'b0);
		core.rd(`CTRL_OFS, d);
		chk_dat(d, 32'h4042);
		sys_pulse(1'b1);
		core.rd(`CTRL_OFS, d);
		chk_dat(d, 32'h0);
		// a run cut short by the system reset leaves the fault set
		core.wr(`EA_OFS, 4'h3, 32'h0402);
		core.wr(`LOW_OFS, 4'h3, 32'h0);
		core.start(16'hC003);
		chk_flag(stall, 1'b1);
		sys_pulse(1'b0);
		chk_flag(stall, 1'b0);
		core.rd(`CTRL_OFS, d);
		chk_dat(d, 32'h6003);
		core.start(16'hC04F);
		run_len(n);
		chk_len(n, BULK_N);
		rd_word(16'h0400, 24'hFFFFFF);
		// remaining listed codes and some unlisted ones: runs or is ignored without fault
		core.wr(`PAGE_OFS, 4'h1, 32'h80);
		foreach (rows[r])
		begin
			core.start(rows[r].ctrl);
			chk_flag(stall, rows[r].run);
			run_len(n);
			core.rd(`CTRL_OFS, d);
			chk_dat(d & 32'h2000, 32'h0);
		end
		test_done();
	end
endmodule // flash_self_program_control_test
